// [rtl/scc_params.svh]
/*
  Constants for the scratchpad copy command interpreter.
  Assumes inclusion by the package, the checker and the bench only.
*/
`ifndef SCC_PARAMS_SVH
`define SCC_PARAMS_SVH

`define SCC_CMD_COPY        8'h5A
`define SCC_CMD_RSTMASTER   8'hF0
`define SCC_CMD_RSTPULSE    8'hB4
`define SCC_PTR_STATUS      8'hF0
`define SCC_PTR_RESET       8'hF0
`define SCC_BIT_DEST        7
`define SCC_POS_PAGE        4
`define SCC_BIT_SEGMODE     3
`define SCC_POS_SEG         0
`define SCC_SEG_BYTES       4
`define SCC_PAGE_BYTES      32
`define SCC_FULL_PERIODS    4'h8
`define SCC_SEG_PERIODS     4'h1
`define SCC_CLK_HZ          20000000
`define SCC_PROG_US         10
`define SCC_PROG_CYCLES     ((`SCC_PROG_US * (`SCC_CLK_HZ / 1000000)))

`endif

// [rtl/scc_pkg.sv]
/*
  Types for the scratchpad copy command interpreter.
  Assumes scc_params.svh sits on the include path.
*/
package scc_pkg;
  `include "scc_params.svh"

  // Byte from the I2C slave front end
  typedef struct packed {
    logic       valid;
    logic       first;
    logic [7:0] data;
  } scc_rx_t;

  // Write request toward the user EEPROM
  typedef struct packed {
    logic       we;
    logic       page;
    logic [4:0] addr;
    logic [7:0] data;
  } scc_ee_t;

  typedef enum logic [2:0] {
    SCC_IDLE,
    SCC_PARAM,
    SCC_WRITE,
    SCC_BUSY
  } scc_state_t;
endpackage : scc_pkg

// [rtl/scc_period_timer.sv]
/*
  Counts whole EEPROM programming periods while enabled.
  The first period is one cycle short: the start pulse covers it.
  Assumes one clock; run drops when the count is done.
*/
`timescale 1ns/10ps
module scc_period_timer
  import scc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       start,
  input  wire logic [3:0] periods,
  output logic            run
);
  localparam int unsigned PC = `SCC_PROG_CYCLES;

  logic [15:0] cyc_q;
  logic [3:0]  left_q;

  // ==========================================================
  // Period countdown
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cyc_q  <= 16'h0000;
      left_q <= 4'h0;
      run    <= 1'b0;
    end else if (start) begin
      cyc_q  <= 16'(PC - 2);
      left_q <= periods;
      run    <= (periods != 4'h0);
    end else if (run) begin
      if (cyc_q != 16'h0000) begin
        cyc_q <= cyc_q - 16'h0001;
      end else if (left_q == 4'h1) begin
        left_q <= 4'h0;
        run    <= 1'b0;
      end else begin
        left_q <= left_q - 4'h1;
        cyc_q  <= 16'(PC - 1);
      end
    end
  end
endmodule : scc_period_timer

// [rtl/scc_copy_cmd.sv]
/*
  Function command interpreter for the copy scratchpad command.
  Assumes an I2C slave front end that hands over each written byte
  with a first-byte flag, asks for the acknowledge one cycle later,
  and consults addr_ack_ok before acknowledging its address.
*/
// Behaviour
// - Acknowledge valid bytes, refuse invalid ones
// - Only an accepted copy parameter moves the read pointer
// - Code 5Ah is copy, one parameter follows
// - Segment source is scratchpad bytes at segment
// - Protected target: no writes, no busy
// - Busy one or eight periods from acknowledge
// - Pointer to master status, nothing else changes
// - Bit 7 destination, bits 5:4 page select
// - Bit 3 chooses full page or segment
// - Any protected block in the target page forces segment mode
// - All eight segment codes valid, four bytes each
`timescale 1ns/10ps
module scc_copy_cmd
  import scc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire scc_rx_t     rx,
  input  wire logic [1:0]  page_protect_any,
  input  wire logic [1:0]  page_protect_all,
  input  wire logic [7:0]  sp_rdata,
  output logic             ack_valid,
  output logic             ack,
  output logic [7:0]       read_ptr,
  output logic             addr_ack_ok,
  output logic [4:0]       sp_raddr,
  output scc_ee_t          ee
);
  scc_state_t state_q;
  logic       target_page_select_q;
  logic       full_q;
  logic [2:0] segment_index_q;
  logic [4:0] cnt_q;
  logic [4:0] last_q;
  logic       rd_pend_q;
  logic       tstart_q;
  logic [3:0] periods_q;
  logic       run;

  logic [7:0] b;
  logic       param_ok;
  logic       locked;
  logic       seg_mode;
  assign b = rx.data;
  // Destination must be user memory, page 0 or 1
  assign param_ok = b[`SCC_BIT_DEST] && (b[5] == 1'b0);
  assign locked   = page_protect_all[b[`SCC_POS_PAGE]];
  assign seg_mode = b[`SCC_BIT_SEGMODE] | page_protect_any[b[`SCC_POS_PAGE]];

  // ==========================================================
  // Command decode and acknowledge
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q              <= SCC_IDLE;
      ack_valid            <= 1'b0;
      ack                  <= 1'b0;
      read_ptr             <= `SCC_PTR_RESET;
      target_page_select_q <= 1'b0;
      full_q               <= 1'b0;
      segment_index_q      <= 3'h0;
      tstart_q             <= 1'b0;
      periods_q            <= 4'h0;
    end else begin
      ack_valid <= 1'b0;
      tstart_q  <= 1'b0;
      if (rx.valid && addr_ack_ok && state_q != SCC_WRITE && !run) begin
        ack_valid <= 1'b1;
        if (rx.first) begin
          // Only the copy code is handled here
          ack <= (b == `SCC_CMD_COPY);
          state_q <= (b == `SCC_CMD_COPY) ? SCC_PARAM : SCC_IDLE;
        end else if (state_q == SCC_PARAM) begin
          ack      <= param_ok;
          state_q  <= SCC_IDLE;
          if (param_ok) begin
            read_ptr             <= `SCC_PTR_STATUS;
            target_page_select_q <= b[`SCC_POS_PAGE];
            full_q               <= ~seg_mode;
            segment_index_q      <= b[2:0];
            if (!locked) begin
              state_q   <= SCC_WRITE;
              tstart_q  <= 1'b1;
              periods_q <= seg_mode ? `SCC_SEG_PERIODS : `SCC_FULL_PERIODS;
            end
          end
        end else begin
          ack <= 1'b0;
        end
      end else if (state_q == SCC_WRITE && !tstart_q && !rd_pend_q && cnt_q == last_q) begin
        // Leave on the edge that writes the last byte, so it is not repeated
        state_q <= SCC_IDLE;
      end
    end
  end

  // ==========================================================
  // Scratchpad to EEPROM transfer
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q     <= 5'h00;
      last_q    <= 5'h00;
      rd_pend_q <= 1'b0;
      sp_raddr  <= 5'h00;
      ee        <= '0;
    end else begin
      ee.we <= 1'b0;
      if (tstart_q) begin
        // Segment n covers bytes 4n to 4n+3
        cnt_q     <= full_q ? 5'h00 : {segment_index_q, 2'b00};
        last_q    <= full_q ? 5'h1F : {segment_index_q, 2'b11};
        sp_raddr  <= full_q ? 5'h00 : {segment_index_q, 2'b00};
        rd_pend_q <= 1'b1;
      end else if (state_q == SCC_WRITE) begin
        if (rd_pend_q) begin
          rd_pend_q <= 1'b0;
        end else begin
          ee.we     <= 1'b1;
          ee.page   <= target_page_select_q;
          ee.addr   <= cnt_q;
          ee.data   <= sp_rdata;
          if (cnt_q != last_q) begin
            cnt_q     <= cnt_q + 5'h01;
            sp_raddr  <= cnt_q + 5'h01;
            rd_pend_q <= 1'b1;
          end
        end
      end
    end
  end

  // ==========================================================
  // Busy window: address refused while programming
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      addr_ack_ok <= 1'b1;
    end else begin
      addr_ack_ok <= !(run || tstart_q || state_q == SCC_WRITE);
    end
  end

  scc_period_timer u_timer (
    .clk     (clk),
    .rstn    (rstn),
    .start   (tstart_q),
    .periods (periods_q),
    .run     (run)
  );
endmodule : scc_copy_cmd

// [verif/scc_monitor.sv]
/* Checker on the scc_copy_cmd ports, bound to every instance. Assumes one clock domain. */
`timescale 1ns/10ps
`include "scc_params.svh"
module scc_monitor
  import scc_pkg::*;
(
  input wire logic       clk,
  input wire logic       rstn,
  input wire scc_rx_t    rx,
  input wire logic [1:0] page_protect_all,
  input wire logic       ack_valid,
  input wire logic       ack,
  input wire logic       addr_ack_ok,
  input wire scc_ee_t    ee
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  int busy_n;
  always_ff @(posedge clk or negedge rstn)
    if (!rstn) busy_n <= 0;
    else busy_n <= addr_ack_ok ? 0 : busy_n + 1;
  sequence s_cmd; rx.valid && rx.first && addr_ack_ok; endsequence
  property p_verdict; s_cmd |=> ack_valid; endproperty
  a_verdict: assert property (p_verdict) else $error("no verdict");
  property p_code; s_cmd |=> ack == ($past(rx.data) == 8'h5A); endproperty
  a_code: assert property (p_code) else $error("code verdict");
  property p_cause; ack_valid |-> $past(rx.valid && addr_ack_ok); endproperty
  a_cause: assert property (p_cause) else $error("stray verdict");
  property p_ignore; rx.valid && !addr_ack_ok |=> !ack_valid; endproperty
  a_ignore: assert property (p_ignore) else $error("busy verdict");
  property p_we; ee.we |-> !addr_ack_ok; endproperty
  a_we: assert property (p_we) else $error("write not busy");
  property p_lock; ack_valid && ack && &page_protect_all |=> addr_ack_ok [*3]; endproperty
  a_lock: assert property (p_lock) else $error("locked busy");
  property p_len; $rose(addr_ack_ok) |-> busy_n inside {`SCC_PROG_CYCLES, 8*`SCC_PROG_CYCLES}; endproperty
  a_len: assert property (p_len) else $error("busy length");
  property p_hold; $fell(addr_ack_ok) |=> !addr_ack_ok [*8]; endproperty
  a_hold: assert property (p_hold) else $error("busy short");
endmodule : scc_monitor
bind scc_copy_cmd scc_monitor u_mon (.clk, .rstn, .rx, .page_protect_all, .ack_valid, .ack,
  .addr_ack_ok, .ee);

// [verif/scc_sp_model.sv]
/* Scratchpad model: byte at a reads A0h or a, one cycle late. Needs clk. */
`timescale 1ns/10ps
module scc_sp_model
(
  input  wire logic       clk,
  input  wire logic [4:0] sp_raddr,
  output logic      [7:0] sp_rdata
);
  always_ff @(posedge clk) sp_rdata <= {3'h5, sp_raddr};
endmodule : scc_sp_model

// [verif/testbench.sv]
/* Bench for scc_copy_cmd. Needs the checker and scratchpad model. */
`timescale 1ns/10ps
`include "scc_params.svh"
module testbench
  import scc_pkg::*;
;
  logic       clk = 1'b0, rstn = 1'b0, ack_valid, ack, addr_ack_ok, la, wp;
  logic [1:0] pa = 2'h0, pl = 2'h0;
  logic [7:0] read_ptr, sp_rdata;
  logic [4:0] sp_raddr, wa;
  scc_rx_t    rx = '0;
  scc_ee_t    ee;
  int         nv, wn, bsy, err_count, comparisons;
  localparam int P = `SCC_PROG_CYCLES;
  always #25 clk = ~clk;
  scc_copy_cmd DUT (.clk, .rstn, .rx, .page_protect_any(pa), .page_protect_all(pl),
    .sp_rdata, .ack_valid, .ack, .read_ptr, .addr_ack_ok, .sp_raddr, .ee);
  scc_sp_model u_sp (.clk, .sp_raddr, .sp_rdata);
  task automatic cmp(input logic [15:0] g, input logic [15:0] e);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %0t %h %h", $time, g, e);
    end
  endtask : cmp
  always @(posedge clk) begin
    nv += ack_valid;
    if (ack_valid) la = ack;
    bsy += !addr_ack_ok;
    wn += ee.we;
    if (ee.we) {wp, wa} = {ee.page, ee.addr};
    if (ee.we) cmp(16'(ee.data), {11'h005, ee.addr});
  end
  task automatic snd(input logic f, input logic [7:0] d, input int n, input logic a);
    nv = 0;
    @(negedge clk) rx = '{1'b1, f, d};
    @(negedge clk) rx = '0;
    repeat (2) @(negedge clk);
    cmp(16'(nv), 16'(n));
    if (n > 0) cmp(16'(la), 16'(a));
  endtask : snd
  task automatic cp(input logic [7:0] p, input logic ok, input int nw, input logic [5:0] last,
                    input int bz);
    bsy = 0;
    wn = 0;
    snd(1'b1, 8'h5A, 1, 1'b1);
    snd(1'b0, p, 1, ok);
    if (ok) cmp(16'(read_ptr), 16'h00F0);
    if (bz > 0) snd(1'b1, 8'h5A, 0, 1'b0);
    repeat (1700) @(negedge clk);
    cmp(16'(bsy), 16'(bz));
    cmp(16'(wn), 16'(nw));
    if (nw > 0) cmp(16'({wp, wa}), 16'(last));
  endtask : cp
  task automatic t_bad;
    snd(1'b1, 8'h33, 1, 1'b0);
    snd(1'b0, 8'h88, 1, 1'b0);
    cp(8'h08, 1'b0, 0, 6'h00, 0);
    cp(8'hA8, 1'b0, 0, 6'h00, 0);
    cp(8'hB8, 1'b0, 0, 6'h00, 0);
  endtask : t_bad
  task automatic t_seg;
    for (int s = 0; s < 8; s++)
      cp(8'h98 | 8'(s) | (s == 5 ? 8'h40 : 8'h00), 1'b1, 4, 6'(35 + 4 * s), P);
  endtask : t_seg
  task automatic t_page;
    cp(8'h80, 1'b1, 32, 6'h1F, 8 * P);
    pa = 2'h1;
    cp(8'h82, 1'b1, 4, 6'h0B, P);
    pl = 2'h3;
    pa = 2'h3;
    cp(8'h98, 1'b1, 0, 6'h00, 0);
  endtask : t_page
  task automatic close_out;
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : close_out
  initial begin
    repeat (12) @(negedge clk);
    rstn = 1'b1;
    t_bad;
    t_seg;
    t_page;
    close_out;
  end
  initial begin
    #2000000;
    err_count++;
    close_out;
  end
endmodule : testbench
